// ### inc/gcs_defines.svh
// Timing and count constants of the glitchless clock switchover
`ifndef GCS_DEFINES_SVH
`define GCS_DEFINES_SVH

// ==========================================================
// System clock
`define GCS_CLK_PERIOD_NS      10
`define GCS_CLK_MHZ            100

// ==========================================================
// Supply-up reset timing: 12 ms per uF, i.e. 12 us per nF
`define GCS_POR_US_PER_NF      12
`define GCS_CAP_NF_DEFAULT     1000
`define GCS_POR_CYCLES_DEFAULT \
  (`GCS_CAP_NF_DEFAULT * `GCS_POR_US_PER_NF * `GCS_CLK_MHZ)

// ==========================================================
// Switchover stage lengths
`define GCS_STALL_CYCLES       64
`define GCS_LOW_EDGES          2
`define GCS_HIGH_EDGES         1
`define GCS_SEL_LIMIT_CYCLES   17

`endif

// ### inc/gcs_pkg.sv
// Types of the glitchless clock switchover
package gcs_pkg;

  // ========================================================
  // Switchover sequence states
  typedef enum logic [2:0] {
    GCS_FOLLOW,
    GCS_DRAIN,
    GCS_HOLD_HIGH,
    GCS_DROP,
    GCS_HOLD_LOW
  } gcs_state_t;

endpackage

// ### core/gcs_sync.sv
// Two-stage synchroniser bank for asynchronous pins
`timescale 1ns/100ps
`default_nettype none

module gcs_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Asynchronous inputs
  input  wire logic [WIDTH-1:0] async_in,
  // Synchronised outputs
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // ========================================================
  // Two flip-flops per bit
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule // gcs_sync

`default_nettype wire

// ### core/gcs_switchover.sv
// Glitchless two-input clock switchover with failsafe hold
`timescale 1ns/100ps
`default_nettype none
`include "gcs_defines.svh"

// Notes on behaviour
// - Running: follow current, hold low, follow target
// - Current stuck high: high, low, then target
// - Stretched cycle phases exceed half target period
// - Current stuck low: low, then target
// - Amplitude loss acts as last valid level
// - Dead selected clock gives stable output level
// - Slowly degrading toggling clock passes unfiltered
// - Supply-up reset starts logic known, timed
// - Timing pin tied high: plain multiplexer
// - Following new clock within 17 cycles
// - Lost amplitude latches last valid level
module gcs_switchover #(
  parameter int unsigned POR_CYCLES   = `GCS_POR_CYCLES_DEFAULT,
  parameter int unsigned STALL_CYCLES = `GCS_STALL_CYCLES,
  parameter int unsigned LOW_EDGES    = `GCS_LOW_EDGES,
  parameter int unsigned HIGH_EDGES   = `GCS_HIGH_EDGES
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Reference clocks and their amplitude detectors
  input  wire logic clock_input_a,
  input  wire logic clock_input_b,
  input  wire logic amplitude_ok_a,
  input  wire logic amplitude_ok_b,
  // Control pins
  input  wire logic clock_select,
  input  wire logic reset_timing_tied_high,
  // Clock output and status
  output logic      clock_out,
  output logic      selected_index,
  output logic      supply_reset_busy
);

  localparam int unsigned PORW = $clog2(POR_CYCLES + 1);
  localparam int unsigned STW  = $clog2(STALL_CYCLES + 1);
  localparam int unsigned EW   = $clog2(LOW_EDGES + HIGH_EDGES + 1);

  // ========================================================
  // Parameter checks
  if (STALL_CYCLES < 2 || LOW_EDGES < 1 || HIGH_EDGES < 1 ||
      POR_CYCLES < 1) begin : g_bad_param
    $error("gcs_switchover: unsupported parameter value");
  end

  // ========================================================
  // Input synchronisers
  logic [5:0] pin_q;

  gcs_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in ({reset_timing_tied_high, clock_select, amplitude_ok_b,
                amplitude_ok_a, clock_input_b, clock_input_a}),
    .sync_out (pin_q)
  );

  logic [1:0] clk_q;
  logic [1:0] amp_q;
  logic       sel_q;
  logic       bypass_q;

  assign clk_q    = pin_q[1:0];
  assign amp_q    = pin_q[3:2];
  assign sel_q    = pin_q[4];
  assign bypass_q = pin_q[5];

  // ========================================================
  // Supply-up reset timer
  logic [PORW-1:0] por_cnt_r;
  logic            por_busy;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      por_cnt_r <= '0;
    end else if (por_busy) begin
      por_cnt_r <= por_cnt_r + PORW'(1);
    end
  end

  assign por_busy = (por_cnt_r != PORW'(POR_CYCLES));

  // ========================================================
  // Last valid level, edge and stall detection per clock
  logic [1:0]          last_lvl_r;
  logic [1:0]          prev_r;
  logic [1:0]          eff;
  logic [1:0]          rise;
  logic [1:0]          fall;
  logic [1:0]          stopped;
  logic [1:0][STW-1:0] idle_r;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      eff[i]     = amp_q[i] ? clk_q[i] : last_lvl_r[i];
      rise[i]    = eff[i] & ~prev_r[i];
      fall[i]    = ~eff[i] & prev_r[i];
      stopped[i] = (idle_r[i] == STW'(STALL_CYCLES));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      last_lvl_r <= '0;
      prev_r     <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (amp_q[i]) begin
          last_lvl_r[i] <= clk_q[i];
        end
      end
      prev_r <= eff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      idle_r <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rise[i] || fall[i]) begin
          idle_r[i] <= '0;
        end else if (!stopped[i]) begin
          idle_r[i] <= idle_r[i] + STW'(1);
        end
      end
    end
  end

  // ========================================================
  // Switchover sequencer
  gcs_pkg::gcs_state_t state_r;
  logic                cur_r;
  logic                tgt;
  logic [EW-1:0]       cnt_r;
  logic                out_r;

  assign tgt = ~cur_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || por_busy) begin
      state_r <= gcs_pkg::GCS_FOLLOW;
      cur_r   <= 1'b0;
      cnt_r   <= '0;
    end else if (bypass_q) begin
      state_r <= gcs_pkg::GCS_FOLLOW;
      cur_r   <= sel_q;
      cnt_r   <= '0;
    end else begin
      unique case (state_r)
        gcs_pkg::GCS_FOLLOW: begin
          cnt_r <= '0;
          if (sel_q != cur_r) begin
            if (!stopped[cur_r]) begin
              state_r <= gcs_pkg::GCS_DRAIN;
            end else if (eff[cur_r]) begin
              state_r <= gcs_pkg::GCS_HOLD_HIGH;
            end else begin
              state_r <= gcs_pkg::GCS_HOLD_LOW;
            end
          end
        end
        gcs_pkg::GCS_DRAIN: begin
          if (fall[cur_r] || (stopped[cur_r] && !eff[cur_r])) begin
            state_r <= gcs_pkg::GCS_HOLD_LOW;
          end else if (stopped[cur_r]) begin
            state_r <= gcs_pkg::GCS_HOLD_HIGH;
          end
        end
        gcs_pkg::GCS_HOLD_HIGH: begin
          if (rise[tgt]) begin
            cnt_r <= cnt_r + EW'(1);
          end
          if (cnt_r == EW'(HIGH_EDGES)) begin
            state_r <= gcs_pkg::GCS_DROP;
          end
        end
        gcs_pkg::GCS_DROP: begin
          if (fall[tgt]) begin
            state_r <= gcs_pkg::GCS_HOLD_LOW;
            cnt_r   <= '0;
          end
        end
        gcs_pkg::GCS_HOLD_LOW: begin
          if (fall[tgt]) begin
            cnt_r <= cnt_r + EW'(1);
          end
          if (cnt_r == EW'(LOW_EDGES)) begin
            state_r <= gcs_pkg::GCS_FOLLOW;
            cur_r   <= tgt;
            cnt_r   <= '0;
          end
        end
      endcase
    end
  end

  // ========================================================
  // Output level
  always_ff @(posedge clk_sys) begin
    if (sys_rst || por_busy) begin
      out_r <= 1'b0;
    end else if (bypass_q) begin
      out_r <= eff[sel_q];
    end else begin
      unique case (state_r)
        gcs_pkg::GCS_FOLLOW,
        gcs_pkg::GCS_DRAIN: out_r <= eff[cur_r];
        gcs_pkg::GCS_HOLD_HIGH,
        gcs_pkg::GCS_DROP: out_r <= 1'b1;
        gcs_pkg::GCS_HOLD_LOW: out_r <= 1'b0;
      endcase
    end
  end

  assign clock_out         = out_r;
  assign selected_index    = cur_r;
  assign supply_reset_busy = por_busy;

endmodule // gcs_switchover

`default_nettype wire

// ### dv/gcs_switchover_properties.sv
// Concurrent checks on the clock switchover ports
`timescale 1ns/100ps
`default_nettype none
`include "gcs_defines.svh"

module gcs_switchover_properties #(
  parameter int unsigned POR_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Watched pins
  input wire logic clock_input_a,
  input wire logic clock_input_b,
  input wire logic amplitude_ok_a,
  input wire logic amplitude_ok_b,
  input wire logic clock_select,
  input wire logic reset_timing_tied_high,
  input wire logic clock_out,
  input wire logic selected_index,
  input wire logic supply_reset_busy
);
  // Seventeen periods of the slower bench source, in system cycles
  localparam int SEL_LIM = `GCS_SEL_LIMIT_CYCLES * 14;
  int lag_r;
  int por_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Counters, sequences and properties
  always_ff @(posedge clk_sys)
    lag_r <= (sys_rst || supply_reset_busy ||
              selected_index == clock_select) ? 0 : lag_r + 1;
  always_ff @(posedge clk_sys)
    por_r <= (sys_rst || !supply_reset_busy) ? 0 : por_r + 1;
  sequence rpe_on;
    (!reset_timing_tied_high && !supply_reset_busy)[*4];
  endsequence
  sequence byp_on;
    (reset_timing_tied_high && !supply_reset_busy &&
     $stable(clock_select))[*6];
  endsequence
  a_rst_known: assert property (
    disable iff (1'b0) sys_rst |=>
      supply_reset_busy && !clock_out && !selected_index)
    else $error("outputs not cleared");
  a_por_bound: assert property (
    por_r <= POR_CYCLES + 2) else $error("supply reset too long");
  a_runt_high: assert property (
    rpe_on ##0 $rose(clock_out) |=> clock_out[*3])
    else $error("short high pulse");
  a_runt_low: assert property (
    rpe_on ##0 $fell(clock_out) |=> !clock_out[*3])
    else $error("short low pulse");
  a_switch_low: assert property (
    rpe_on ##0 $changed(selected_index) |-> !clock_out && !$past(clock_out))
    else $error("output not low at handover");
  a_sel_bound: assert property (
    lag_r <= SEL_LIM) else $error("switchover too slow");
  a_bypass_mux: assert property (
    byp_on |-> selected_index == clock_select)
    else $error("bypass index wrong");
  a_bypass_follow: assert property (
    byp_on ##0 ($past(amplitude_ok_a, 3) && $past(amplitude_ok_b, 3))
      |-> clock_out == (clock_select ? $past(clock_input_b, 3) :
                                       $past(clock_input_a, 3)))
    else $error("bypass output not following");
  a_amp_hold: assert property (
    (!amplitude_ok_a && !selected_index && !clock_select)[*8]
      |-> $stable(clock_out)) else $error("output moved on dead clock");
endmodule // gcs_switchover_properties

bind gcs_switchover gcs_switchover_properties #(.POR_CYCLES(POR_CYCLES))
  u_props (.clk_sys, .sys_rst, .clock_input_a, .clock_input_b,
  .amplitude_ok_a, .amplitude_ok_b, .clock_select, .reset_timing_tied_high,
  .clock_out, .selected_index, .supply_reset_busy);
`default_nettype wire

// ### dv/gcs_clk_source.sv
// Behavioural reference clock source
`timescale 1ns/100ps
`default_nettype none

module gcs_clk_source #(
  parameter int HALF_NS = 50
) (
  // Controls
  input  wire logic run,
  input  wire logic park_level,
  input  wire logic amp_ok,
  // Clock line
  output logic      clk_o
);
  // ==========================================================
  // Toggle, park after a full phase, or noise when amplitude is gone
  initial begin
    clk_o = 1'b0;
    #3;
    forever begin
      if (!amp_ok) begin
        #10 clk_o = ~clk_o;
      end else if (run) begin
        #(HALF_NS) clk_o = ~clk_o;
      end else begin
        #(HALF_NS) clk_o = park_level;
      end
    end
  end
endmodule // gcs_clk_source
`default_nettype wire

// ### dv/test_glitchless_clock_switchover.sv
// Self-checking bench for the glitchless clock switchover
`timescale 1ns/100ps
`default_nettype none
`include "gcs_defines.svh"

module test_glitchless_clock_switchover;
  logic clk_sys, sys_rst, clock_select, reset_timing_tied_high;
  logic amplitude_ok_a, amplitude_ok_b, clock_input_a, clock_input_b;
  logic clock_out, selected_index, supply_reset_busy;
  logic run_a, run_b, park_a, park_b, held;
  int   bad_count, total_checks, rises, falls;
  logic [2:0] pin_hist [$];
  // Seventeen periods of the slower source, in system cycles
  localparam int SEL_LIMIT = `GCS_SEL_LIMIT_CYCLES * 14;
  // ==========================================================
  // Sources at 1.4 to 1, device with short timers
  gcs_clk_source #(.HALF_NS(50)) src_a (.run(run_a), .park_level(park_a),
    .amp_ok(amplitude_ok_a), .clk_o(clock_input_a));
  gcs_clk_source #(.HALF_NS(70)) src_b (.run(run_b), .park_level(park_b),
    .amp_ok(amplitude_ok_b), .clk_o(clock_input_b));
  gcs_switchover #(.POR_CYCLES(8), .STALL_CYCLES(16)) dut (.clk_sys,
    .sys_rst, .clock_input_a, .clock_input_b, .amplitude_ok_a,
    .amplitude_ok_b, .clock_select, .reset_timing_tied_high, .clock_out,
    .selected_index, .supply_reset_busy);

  task automatic chk(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Pin history model: output is the selected pin two edges back
  always @(posedge clk_sys) begin
    pin_hist.push_back({clock_select, clock_input_b, clock_input_a});
    if (pin_hist.size() > 3) void'(pin_hist.pop_front());
  end

  task automatic follow_check(input int cycles);
    logic [2:0] h;
    repeat (cycles) begin
      @(posedge clk_sys);
      #1;
      h = pin_hist[0];
      chk("model output", clock_out, h[2] ? h[1] : h[0]);
    end
    @(negedge clk_sys);
  endtask

  task automatic switch_to(input logic sel, input int exp_r, exp_f);
    logic last;
    @(negedge clk_sys);
    clock_select = sel;
    last = clock_out;
    rises = 0;
    falls = 0;
    for (int n = 0; n < SEL_LIMIT && selected_index !== sel; n++) begin
      @(posedge clk_sys);
      #1;
      rises += (clock_out && !last);
      falls += (!clock_out && last);
      last = clock_out;
    end
    chk("selected index", selected_index, sel);
    if (exp_r >= 0) chk("rises", rises[15:0], exp_r[15:0]);
    if (exp_f >= 0) chk("falls", falls[15:0], exp_f[15:0]);
    @(negedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #100000;
    bad_count++;
    conclude();
  end

  initial begin
    {sys_rst, run_a, run_b, amplitude_ok_a, amplitude_ok_b} = 5'h1f;
    {park_a, park_b, clock_select, reset_timing_tied_high} = 4'h0;
    void'($urandom(57097));
    repeat (10) @(negedge clk_sys);
    chk("busy in reset", supply_reset_busy, 1'b1);
    chk("output in reset", clock_out, 1'b0);
    sys_rst = 1'b0;
    repeat (14) @(negedge clk_sys);
    chk("busy after timer", supply_reset_busy, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      follow_check($urandom_range(60, 20));
      switch_to(!i[0], -1, -1);
    end
    $display("test running switch done");
    park_a = 1'b1;
    run_a = 1'b0;
    repeat (60) @(negedge clk_sys);
    chk("stuck high output", clock_out, 1'b1);
    switch_to(1'b1, 0, 1);
    run_a = 1'b1;
    run_b = 1'b0;
    repeat (60) @(negedge clk_sys);
    chk("stuck low output", clock_out, 1'b0);
    switch_to(1'b0, 0, 0);
    run_b = 1'b1;
    $display("test stuck clocks done");
    follow_check($urandom_range(60, 20));
    amplitude_ok_a = 1'b0;
    repeat (10) @(negedge clk_sys);
    held = clock_out;
    falls = 0;
    repeat (60) begin
      @(negedge clk_sys);
      falls += (clock_out !== held);
    end
    chk("dead clock moves", falls[15:0], 16'h0);
    switch_to(1'b1, 0, held);
    amplitude_ok_a = 1'b1;
    $display("test amplitude loss done");
    reset_timing_tied_high = 1'b1;
    repeat (8) @(negedge clk_sys);
    repeat (8) begin
      clock_select = 1'($urandom_range(1, 0));
      follow_check(8);
      chk("bypass index", selected_index, clock_select);
    end
    $display("test bypass done");
    conclude();
  end
endmodule // test_glitchless_clock_switchover
`default_nettype wire
